// ==== ssi_cfg.svh ====
// Purpose: named constants of the scanner status indicator
// Assumes: 100 MHz core clock
// Notes: definitions only
`ifndef SSI_CFG_SVH
`define SSI_CFG_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define SSI_CLK_HZ 100000000
`define SSI_FLASH_HALF_MS 250
`define SSI_DWELL_MS 1000
`define SSI_FLASH_HALF_CYC ((`SSI_FLASH_HALF_MS) * (`SSI_CLK_HZ / 1000))
`define SSI_DWELL_CYC ((`SSI_DWELL_MS) * (`SSI_CLK_HZ / 1000))

// ----------------------------------------
// register map and fields
// ----------------------------------------
`define SSI_REG_CTRL 12'h000
`define SSI_REG_STATUS 12'h004
`define SSI_REG_MASK 12'h008
`define SSI_REG_STATE 12'h00c
`define SSI_TEXT_BIT 11
`define SSI_CTRL_RST 1'h1
`define SSI_NEV 4
`define SSI_EV_ERR 0
`define SSI_EV_OCC 1
`define SSI_EV_BOOT 2
`define SSI_EV_XFER 3

// ----------------------------------------
// display layout and characters
// ----------------------------------------
`define SSI_DISP_LAST 5'h17
`define SSI_SEQ_LAST_NC 4'h6
`define SSI_SEQ_LAST_C 4'h8
`define SSI_DEG_MAX 8'h63
`define SSI_CH_SPACE 8'h20
`define SSI_CH_H 8'h48
`define SSI_CH_V 8'h56
`define SSI_CH_PLUS 8'h2b
`define SSI_CH_MINUS 8'h2d
`define SSI_CH_ZERO 8'h30
`define SSI_CH_DEG 8'hb0
`define SSI_TEN 8'h0a
`define SSI_LV_H 5'h00
`define SSI_LV_V 5'h06

`endif

// ==== ssi_pkg.sv ====
// Purpose: types shared by the status indicator files
// Assumes: nothing
// Notes: item order doubles as text memory slot number
package ssi_pkg;
   typedef enum logic [1:0] {RI_DEACT, RI_ENABLED, RI_BLOCKED} ssi_intlk_e;
   typedef enum logic [3:0] {
      IT_TYPE, IT_VER, IT_SERIAL, IT_NAME, IT_IP, IT_RADIO, IT_SETUPREQ,
      IT_DATE, IT_SIG, IT_AWAIT, IT_XFER, IT_LEVEL, IT_PAIR
   } ssi_item_e;
endpackage

// ==== ssi_flash.sv ====
// Purpose: free-running flash phase for all flashing lamps
// Assumes: HALF_CYC of two or more
// Notes: one rate for every lamp keeps flashing easy to tell from steady
module ssi_flash #(
   parameter int HALF_CYC = 25000000
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // phase out
   output logic phase_q
);
   logic [31:0] cnt_q;

   // half-period counter, phase toggles at each wrap
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= '0;
         phase_q <= 1'b0;
      end else if (cnt_q == 32'(HALF_CYC - 1)) begin
         cnt_q <= '0;
         phase_q <= ~phase_q;
      end else begin
         cnt_q <= cnt_q + 32'h1;
      end
   end

   flash_rate_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (phase_q != $past(phase_q)) |-> $past(cnt_q) == 32'(HALF_CYC - 1))
      else $error("flash phase toggled off its period");
endmodule

// ==== ssi_text_mem.sv ====
// Purpose: text slots for the display, one byte per character
// Assumes: one write and one read port on the same clock
// Notes: read data come out of a register, one cycle late
module ssi_text_mem #(
   parameter int AW = 9
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // write port
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [7:0] wrData,
   // read port
   input wire logic [AW-1:0] rdAddr,
   output logic [7:0] rdData_q
);
   logic [7:0] mem [0:(1<<AW)-1];

   // array has no reset, software loads it after power-up
   always_ff @(posedge core_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // registered read
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rdData_q <= '0;
      end else begin
         rdData_q <= mem[rdAddr];
      end
   end
endmodule

// ==== ssi_indicator.sv ====
// Purpose: lamps and 24-character text display of the scanner status
// Assumes: all status inputs synchronous to core_clk
// Notes: display text streams out one character per cycle
// Functional notes
// - six lamps; lamps one to three belong to the first protective function
// - lamp 2 off, flashing while field occupied, on when interlock blocked or linked
// - lamp 3 shows warning field; lamp 4 shows warning field 3 in four-field mode
// - lamp 5 flashes for warning field 2 in four-field mode; lamp 6 flashes on error
// - normal operation with stored setup shows active field pair, function letter then pair index
// - boot without setup cycles identity items and setup request, then level
// - boot with setup cycles identity, date, signature, level, then field pair
// - level shows signed whole degrees, H value then V value
// - awaiting message until transfer confirmed, transfer message during transfer
//
// Implementation choices: the plain strobed port and the register offsets.
`include "ssi_cfg.svh"
module ssi_indicator
   import ssi_pkg::*;
#(
   parameter int FLASH_HALF_CYC = `SSI_FLASH_HALF_CYC,
   parameter int DWELL_CYC = `SSI_DWELL_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // register port
   input wire logic [11:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData_q,
   output logic irq_q,
   // scanner state
   input wire logic safetyOutputPairOn,
   input ssi_intlk_e restartInterlock,
   input wire logic protFieldOccupied,
   input wire logic linkedUsed,
   input wire logic linkedEnabled,
   input wire logic warnField1,
   input wire logic warnField2,
   input wire logic warnField3,
   input wire logic fourFieldMode,
   input wire logic errorActive,
   input wire logic bootActive,
   input wire logic setupStored,
   input wire logic setupAwaiting,
   input wire logic setupTransfer,
   input wire logic signed [7:0] levelH,
   input wire logic signed [7:0] levelV,
   input wire logic [7:0] pairFunc,
   input wire logic [6:0] pairIndex,
   // lamps
   output logic lamp1Red_q,
   output logic lamp1Green_q,
   output logic lamp2_q,
   output logic lamp3_q,
   output logic lamp4_q,
   output logic lamp5_q,
   output logic lamp6_q,
   // display character stream
   output logic [4:0] dispPos_q,
   output logic [7:0] dispChar_q,
   output logic dispWe_q
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   // ----------------------------------------
   // functions
   // ----------------------------------------
   // boot sequence item at a given step
   function automatic ssi_item_e seqItem(input logic cfgd, input logic [3:0] idx);
      ssi_item_e it;
      it = IT_TYPE;
      if (idx <= 4'(IT_RADIO)) it = ssi_item_e'(idx);
      else if (!cfgd) it = IT_SETUPREQ;
      else if (idx == 4'(IT_SETUPREQ)) it = IT_DATE;
      else if (idx == 4'(IT_DATE)) it = IT_SIG;
      else it = IT_LEVEL;
      return it;
   endfunction

   // one character of a signed degree value, k: 0 sign/space, 1 tens/sign, 2 ones
   function automatic logic [7:0] degChar(input logic signed [7:0] v, input logic [1:0] k);
      logic [7:0] mag;
      logic [7:0] tens;
      logic [7:0] ones;
      logic [7:0] sgn;
      mag = v[7] ? 8'(-v) : 8'(v);
      if (mag > `SSI_DEG_MAX) mag = `SSI_DEG_MAX;
      tens = mag / `SSI_TEN;
      ones = mag % `SSI_TEN;
      sgn = v[7] ? `SSI_CH_MINUS : `SSI_CH_PLUS;
      // leading zero dropped, sign slides right so digits stay put
      unique case (k)
         2'h0: degChar = (tens != 8'h0) ? sgn : `SSI_CH_SPACE;
         2'h1: degChar = (tens != 8'h0) ? `SSI_CH_ZERO + tens : sgn;
         default: degChar = `SSI_CH_ZERO + ones;
      endcase
   endfunction

   // generated character of level or pair item at a column
   function automatic logic [7:0] genChar(input ssi_item_e it, input logic [4:0] p,
                                          input logic signed [7:0] h, input logic signed [7:0] v,
                                          input logic [7:0] fn, input logic [6:0] idx);
      logic [7:0] t;
      logic [7:0] o;
      logic [4:0] r;
      genChar = `SSI_CH_SPACE;
      t = 8'(idx) / `SSI_TEN;
      o = 8'(idx) % `SSI_TEN;
      if (it == IT_PAIR) begin
         if (p == 5'h0) genChar = fn;
         else if (p == 5'h1) genChar = `SSI_CH_ZERO + ((t != 8'h0) ? t : o);
         else if (p == 5'h2 && t != 8'h0) genChar = `SSI_CH_ZERO + o;
      end else begin
         r = (p >= `SSI_LV_V) ? 5'(p - `SSI_LV_V) : p;
         if (r == 5'h0 && p == `SSI_LV_H) genChar = `SSI_CH_H;
         else if (r == 5'h0) genChar = `SSI_CH_V;
         else if (r <= 5'h3) genChar = degChar((p >= `SSI_LV_V) ? v : h, 2'(r - 5'h1));
         else if (r == 5'h4) genChar = `SSI_CH_DEG;
      end
   endfunction

   // ----------------------------------------
   // register port
   // ----------------------------------------
   logic dispOn_q;
   logic [`SSI_NEV-1:0] status_q;
   logic [`SSI_NEV-1:0] status_d;
   logic [`SSI_NEV-1:0] mask_q;
   logic [`SSI_NEV-1:0] events;
   logic [`SSI_NEV-1:0] clr;
   logic bootDone_q;
   ssi_item_e curItem;
   logic textWr;

   assign textWr = regWr && regAddr[`SSI_TEXT_BIT];
   assign clr = (regWr && regAddr == `SSI_REG_STATUS) ? regWrData[`SSI_NEV-1:0] : '0;

   // control and mask written by software
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         dispOn_q <= `SSI_CTRL_RST;
         mask_q <= '0;
      end else if (regWr && regAddr == `SSI_REG_CTRL) begin
         dispOn_q <= regWrData[0];
      end else if (regWr && regAddr == `SSI_REG_MASK) begin
         mask_q <= regWrData[`SSI_NEV-1:0];
      end
   end

   // read data one cycle after the strobe; unmapped and text read as zero
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         regRdData_q <= '0;
      end else if (regRd) begin
         unique case (regAddr)
            `SSI_REG_CTRL: regRdData_q <= 32'(dispOn_q);
            `SSI_REG_STATUS: regRdData_q <= 32'(status_q);
            `SSI_REG_MASK: regRdData_q <= 32'(mask_q);
            `SSI_REG_STATE: regRdData_q <= 32'({bootDone_q, 4'(curItem)});
            default: regRdData_q <= '0;
         endcase
      end else begin
         regRdData_q <= '0;
      end
   end

   // ----------------------------------------
   // events and interrupt
   // ----------------------------------------
   logic errPrev_q;
   logic occPrev_q;
   logic bootPrev_q;
   logic xferPrev_q;

   assign events[`SSI_EV_ERR] = errorActive && !errPrev_q;
   assign events[`SSI_EV_OCC] = protFieldOccupied && !occPrev_q;
   assign events[`SSI_EV_BOOT] = bootPrev_q && !bootActive;
   assign events[`SSI_EV_XFER] = xferPrev_q && !setupTransfer;
   // a new event beats a write-one clear in the same cycle
   assign status_d = (status_q & ~clr) | events;

   // edge history, sticky status, level interrupt
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         errPrev_q <= 1'b0;
         occPrev_q <= 1'b0;
         bootPrev_q <= 1'b0;
         xferPrev_q <= 1'b0;
         status_q <= '0;
         irq_q <= 1'b0;
      end else begin
         errPrev_q <= errorActive;
         occPrev_q <= protFieldOccupied;
         bootPrev_q <= bootActive;
         xferPrev_q <= setupTransfer;
         status_q <= status_d;
         irq_q <= |(status_d & mask_q);
      end
   end

   set_wins_a: assert property ((events != '0) |=> (status_q & $past(events)) == $past(events))
      else $error("event lost against a status clear");

   // ----------------------------------------
   // lamps
   // ----------------------------------------
   logic flashPhase;

   ssi_flash #(.HALF_CYC(FLASH_HALF_CYC)) ssi_flash_inst (
      .core_clk(core_clk),
      .resetn(resetn),
      .phase_q(flashPhase)
   );

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         lamp1Red_q <= 1'b0;
         lamp1Green_q <= 1'b0;
      end else begin
         lamp1Red_q <= errorActive ? flashPhase : !safetyOutputPairOn;
         lamp1Green_q <= !errorActive && safetyOutputPairOn;
      end
   end

   // occupied field flashes, blocked interlock or linked sensor is steady
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         lamp2_q <= 1'b0;
      end else if (protFieldOccupied) begin
         lamp2_q <= flashPhase;
      end else begin
         lamp2_q <= (restartInterlock == RI_BLOCKED) || (linkedUsed && linkedEnabled);
      end
   end

   // warning field lamps and error lamp
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         lamp3_q <= 1'b0;
         lamp4_q <= 1'b0;
         lamp5_q <= 1'b0;
         lamp6_q <= 1'b0;
      end else begin
         lamp3_q <= warnField1;
         lamp4_q <= fourFieldMode && warnField3;
         lamp5_q <= fourFieldMode && warnField2 && flashPhase;
         lamp6_q <= errorActive && flashPhase;
      end
   end

   lamp2_flash_a: assert property (protFieldOccupied |=> lamp2_q == $past(flashPhase))
      else $error("lamp 2 not flashing with occupied field");
   lamp2_off_a: assert property (!protFieldOccupied && restartInterlock != RI_BLOCKED
      && !linkedUsed |=> !lamp2_q)
      else $error("lamp 2 lit without cause");
   lamp4_mode_a: assert property (!fourFieldMode |=> !lamp4_q && !lamp5_q)
      else $error("four-field lamps lit outside four-field mode");
   lamp5_flash_a: assert property (fourFieldMode && warnField2 |=> lamp5_q == $past(flashPhase))
      else $error("lamp 5 not flashing for warning field 2");
   lamp6_err_a: assert property (errorActive ##1 errorActive |-> lamp6_q == $past(flashPhase))
      else $error("lamp 6 not flashing on error");

   // ----------------------------------------
   // boot sequence and item select
   // ----------------------------------------
   logic [31:0] dwell_q;
   logic [3:0] step_q;
   logic dwellEnd;
   logic [3:0] stepLast;

   assign dwellEnd = dwell_q == 32'(DWELL_CYC - 1);
   assign stepLast = setupStored ? `SSI_SEQ_LAST_C : `SSI_SEQ_LAST_NC;

   // each item dwells, list repeats while booting
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         dwell_q <= '0;
         step_q <= '0;
      end else if (!bootActive) begin
         dwell_q <= '0;
         step_q <= '0;
      end else if (dwellEnd) begin
         dwell_q <= '0;
         step_q <= (step_q >= stepLast) ? 4'h0 : step_q + 4'h1;
      end else begin
         dwell_q <= dwell_q + 32'h1;
      end
   end

   // boot end seen, cleared by a new boot
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bootDone_q <= 1'b0;
      end else if (bootActive) begin
         bootDone_q <= 1'b0;
      end else if (bootPrev_q) begin
         bootDone_q <= 1'b1;
      end
   end

   // transfer messages override boot and normal display
   always_comb begin
      if (setupTransfer) curItem = IT_XFER;
      else if (setupAwaiting) curItem = IT_AWAIT;
      else if (bootActive) curItem = seqItem(setupStored, step_q);
      else if (setupStored) curItem = IT_PAIR;
      else curItem = IT_LEVEL;
   end

   seq_wrap_a: assert property (bootActive && dwellEnd && step_q == `SSI_SEQ_LAST_NC
      && !setupStored |=> step_q == 4'h0)
      else $error("unconfigured boot list did not repeat");
   seq_cfg_a: assert property (bootActive && setupStored && step_q == `SSI_SEQ_LAST_C
      && !setupTransfer && !setupAwaiting |-> curItem == IT_LEVEL)
      else $error("configured boot list does not end on level");
   xfer_msg_a: assert property (setupTransfer |-> curItem == IT_XFER)
      else $error("transfer message not shown");
   await_msg_a: assert property (setupAwaiting && !setupTransfer |-> curItem == IT_AWAIT)
      else $error("awaiting message not shown");

   // ----------------------------------------
   // display scan
   // ----------------------------------------
   logic [4:0] scanPos_q;
   logic [4:0] s1Pos_q;
   logic [7:0] s1Char_q;
   logic s1Gen_q;
   logic s1Blank_q;
   logic s1Valid_q;
   logic [7:0] memData;
   logic isGen;

   assign isGen = (curItem == IT_LEVEL) || (curItem == IT_PAIR);

   ssi_text_mem #(.AW(9)) ssi_text_mem_inst (
      .core_clk(core_clk),
      .resetn(resetn),
      .wrEn(textWr),
      .wrAddr(regAddr[10:2]),
      .wrData(regWrData[7:0]),
      .rdAddr({4'(curItem), scanPos_q}),
      .rdData_q(memData)
   );

   // column counter; one full refresh every 24 cycles
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         scanPos_q <= '0;
      end else begin
         scanPos_q <= (scanPos_q == `SSI_DISP_LAST) ? 5'h0 : scanPos_q + 5'h1;
      end
   end

   // stage one, generated text beside the memory read
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s1Pos_q <= '0;
         s1Char_q <= `SSI_CH_SPACE;
         s1Gen_q <= 1'b0;
         s1Blank_q <= 1'b1;
         s1Valid_q <= 1'b0;
      end else begin
         s1Pos_q <= scanPos_q;
         s1Char_q <= genChar(curItem, scanPos_q, levelH, levelV, pairFunc, pairIndex);
         s1Gen_q <= isGen;
         s1Blank_q <= !dispOn_q;
         s1Valid_q <= 1'b1;
      end
   end

   // stage two, switched-off display writes blanks
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         dispPos_q <= '0;
         dispChar_q <= `SSI_CH_SPACE;
         dispWe_q <= 1'b0;
      end else begin
         dispPos_q <= s1Pos_q;
         dispChar_q <= s1Blank_q ? `SSI_CH_SPACE : (s1Gen_q ? s1Char_q : memData);
         dispWe_q <= s1Valid_q;
      end
   end

   sequence atCol0(ssi_item_e it);
      scanPos_q == 5'h0 && curItem == it && dispOn_q;
   endsequence

   pair_text_a: assert property (atCol0(IT_PAIR) |-> ##2 dispWe_q && dispPos_q == 5'h0
      && dispChar_q == $past(pairFunc, 2))
      else $error("field pair letter missing");
   level_h_a: assert property (atCol0(IT_LEVEL) |-> ##2 dispChar_q == `SSI_CH_H)
      else $error("level text does not start with H");
   level_v_a: assert property (atCol0(IT_LEVEL) ##6 curItem == IT_LEVEL && dispOn_q
      |-> ##2 dispChar_q == `SSI_CH_V)
      else $error("vertical level not marked V");
endmodule

// ==== tb_ssi_indicator.sv ====
// Purpose: self-checking bench of the scanner status indicator
// Assumes: flash half period 4 and boot dwell 8 cycles to keep the run short
// Notes: lamps sampled as one vector; display frames captured from the stream
`include "ssi_cfg.svh"
module tb_ssi_indicator
   import ssi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 4;
   localparam int DWELL = 8;
   logic core_clk = 1'b0, resetn = 1'b0, regWr = 1'b0, regRd = 1'b0;
   logic [11:0] regAddr = 12'h000;
   logic [31:0] regWrData = 32'h0, regRdData_q, rdVal;
   logic irq_q, safeOn = 1'b0, occ = 1'b0, lnkU = 1'b0, lnkE = 1'b0, w1 = 1'b0, w2 = 1'b0, w3 = 1'b0;
   logic four = 1'b0, err = 1'b0, boot = 1'b0, stored = 1'b0, await = 1'b0, xfer = 1'b0;
   ssi_intlk_e intlk = RI_DEACT;
   logic signed [7:0] levH = -8'sd3, levV = 8'sd9;
   logic [7:0] pFn = 8'h41;
   logic [6:0] pIdx = 7'h0c;
   logic lR, lG, l2, l3, l4, l5, l6, dWe;
   logic [4:0] dPos;
   logic [7:0] dChr;
   logic [7:0] frame [24];
   logic [7:0] expF [24];
   logic [6:0] lamps;
   int failures = 0, check_count = 0, cyc = 0;
   assign lamps = {l6, l5, l4, l3, l2, lG, lR};

   // ----------------------------------------
   // clock, timeout and device
   // ----------------------------------------
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   // hang guard: the whole sequence needs well under 3000 cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures = failures + 1;
         $display("mismatch at %0t: run timed out", $time);
         test_done();
      end
   end
   ssi_indicator #(.FLASH_HALF_CYC(HALF), .DWELL_CYC(DWELL)) ssi_indicator_inst (
      .core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData_q(regRdData_q), .irq_q(irq_q),
      .safetyOutputPairOn(safeOn), .restartInterlock(intlk), .protFieldOccupied(occ),
      .linkedUsed(lnkU), .linkedEnabled(lnkE), .warnField1(w1), .warnField2(w2),
      .warnField3(w3), .fourFieldMode(four), .errorActive(err), .bootActive(boot),
      .setupStored(stored), .setupAwaiting(await), .setupTransfer(xfer), .levelH(levH),
      .levelV(levV), .pairFunc(pFn), .pairIndex(pIdx), .lamp1Red_q(lR), .lamp1Green_q(lG),
      .lamp2_q(l2), .lamp3_q(l3), .lamp4_q(l4), .lamp5_q(l5), .lamp6_q(l6),
      .dispPos_q(dPos), .dispChar_q(dChr), .dispWe_q(dWe));

   // ----------------------------------------
   // access and compare tasks
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask
   // read data is taken in the single cycle after the strobe edge
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 d = regRdData_q;
   endtask
   task automatic chkw(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count = check_count + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic rdChk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
      rd(a, rdVal);
      chkw(rdVal & m, exp, "register read");
   endtask
   // settle two cycles, then compare the steady lamp vector
   task automatic lampChk(input logic [6:0] exp);
      tick(2);
      #1 chkw({25'h0, lamps}, {25'h0, exp}, "lamps");
   endtask
   // a flashing lamp is lit in exactly half of four half periods
   task automatic flashChk(input int idx);
      int hi;
      hi = 0;
      tick(3);
      repeat (4 * HALF) begin
         @(negedge core_clk);
         hi = hi + ((lamps[idx] === 1'b1) ? 1 : 0);
      end
      chkw(hi, 2 * HALF, "flash duty");
   endtask
   // wait for column 0, then capture one full line of the stream
   task automatic frameChk(input int cols);
      int k;
      k = 0;
      tick(30);
      // look between edges so the stream is settled
      @(negedge core_clk);
      while (!(dWe === 1'b1 && dPos === 5'h00) && k < 100) begin
         @(negedge core_clk);
         k = k + 1;
      end
      chkw({26'h0, dWe, dPos}, 32'h20, "display start");
      repeat (24) begin
         frame[dPos] = dChr;
         @(negedge core_clk);
      end
      for (int i = 0; i < cols; i++) chkw({24'h0, frame[i]}, {24'h0, expF[i]}, "display char");
   endtask
   task automatic test_done();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      tick(10);
      resetn <= 1'b1;
      // register reset values and unmapped place
      rdChk(`SSI_REG_CTRL, 32'h1, 32'h1);
      rdChk(`SSI_REG_MASK, 32'hf, 32'h0);
      rdChk(12'h010, 32'hffffffff, 32'h0);
      $display("test registers done");
      // steady lamp states
      safeOn <= 1'b1;
      lampChk(7'b0000010); // green, lamp 2 off with interlock deactivated
      safeOn <= 1'b0;
      intlk <= RI_BLOCKED;
      lampChk(7'b0000101); // blocked interlock lights lamp 2
      intlk <= RI_ENABLED;
      lampChk(7'b0000001); // enabled interlock leaves lamp 2 off
      lnkU <= 1'b1;
      lnkE <= 1'b1;
      w1 <= 1'b1;
      w3 <= 1'b1;
      lampChk(7'b0001101); // linked sensor on, lamp 4 dark outside four-field mode
      four <= 1'b1;
      lampChk(7'b0011101); // lamp 4 follows warning field 3
      w2 <= 1'b1;
      flashChk(5); // lamp 5 flashes for warning field 2
      occ <= 1'b1;
      flashChk(2); // lamp 2 flashes while field occupied
      err <= 1'b1;
      flashChk(6); // lamp 6 flashes on error
      flashChk(0); // red part of lamp 1 flashes on error
      $display("test lamps done");
      // events, mask and interrupt
      rdChk(`SSI_REG_STATUS, 32'h3, 32'h3);
      #1 chkw(irq_q, 1'b0, "irq masked");
      wr(`SSI_REG_MASK, 32'h1);
      tick(2);
      #1 chkw(irq_q, 1'b1, "irq raised");
      wr(`SSI_REG_STATUS, 32'h3);
      tick(2);
      #1 chkw(irq_q, 1'b0, "irq cleared");
      rdChk(`SSI_REG_STATUS, 32'hf, 32'h0);
      err <= 1'b0;
      occ <= 1'b0;
      $display("test interrupt done");
      // level text, signed whole degrees
      for (int i = 0; i < 24; i++) expF[i] = `SSI_CH_SPACE;
      expF[0] = `SSI_CH_H;
      expF[2] = `SSI_CH_MINUS;
      expF[3] = 8'h33;
      expF[4] = `SSI_CH_DEG;
      expF[6] = `SSI_CH_V;
      expF[8] = `SSI_CH_PLUS;
      expF[9] = 8'h39;
      expF[10] = `SSI_CH_DEG;
      frameChk(24); // level shown after unconfigured start
      // normal operation field pair
      stored <= 1'b1;
      expF[0] = 8'h41;
      expF[1] = 8'h31;
      expF[2] = 8'h32;
      frameChk(3); // function letter then pair index
      wr(`SSI_REG_CTRL, 32'h0);
      for (int i = 0; i < 3; i++) expF[i] = `SSI_CH_SPACE;
      frameChk(3); // display off shows blanks
      wr(`SSI_REG_CTRL, 32'h1);
      $display("test display done");
      // boot sequences with and without stored setup
      boot <= 1'b1;
      tick(3);
      rdChk(`SSI_REG_STATE, 32'hf, IT_TYPE); // sequence starts at sensor type
      tick(DWELL - 2);
      rdChk(`SSI_REG_STATE, 32'hf, IT_VER); // next item after one dwell
      tick(6 * DWELL);
      rdChk(`SSI_REG_STATE, 32'hf, IT_SIG); // configured sequence reaches signature
      tick(DWELL - 2);
      rdChk(`SSI_REG_STATE, 32'hf, IT_LEVEL); // level closes configured sequence
      stored <= 1'b0;
      tick(DWELL - 2);
      rdChk(`SSI_REG_STATE, 32'hf, IT_TYPE); // configured sequence wraps
      tick(6 * DWELL - 2);
      rdChk(`SSI_REG_STATE, 32'hf, IT_SETUPREQ); // unconfigured ends with request
      boot <= 1'b0;
      tick(2);
      rdChk(`SSI_REG_STATE, 32'h1f, 32'h10 | IT_LEVEL); // level and boot done after boot ends
      rdChk(`SSI_REG_STATUS, 32'h4, 32'h4);
      $display("test boot done");
      // setup transfer messages and priority
      await <= 1'b1;
      tick(2);
      rdChk(`SSI_REG_STATE, 32'hf, IT_AWAIT); // awaiting message shown
      // load columns 0 and 1 of the awaiting slot; text area reads back zero
      wr(12'hc80, 32'h41);
      wr(12'hc84, 32'h57);
      rdChk(12'hc80, 32'hffffffff, 32'h0);
      expF[0] = 8'h41;
      expF[1] = 8'h57;
      frameChk(2); // awaiting text comes from its text slot
      xfer <= 1'b1;
      tick(2);
      rdChk(`SSI_REG_STATE, 32'hf, IT_XFER); // transfer message wins
      xfer <= 1'b0;
      await <= 1'b0;
      tick(2);
      rdChk(`SSI_REG_STATUS, 32'h8, 32'h8);
      rdChk(`SSI_REG_STATE, 32'hf, IT_LEVEL); // message ends with confirmation
      $display("test setup transfer done");
      test_done();
   end
endmodule
